// *** bench/power_mode_controller_sva.sv ***
/*
 * Port-level checks of the mode controller.
 * Assumes it is bound to the top module with all names matching.
 */
`timescale 1ns/1ns
`default_nettype none
module power_mode_controller_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pmc_pkg::ADDR_W-1:0] paddr,
    input wire logic [pmc_pkg::DATA_W-1:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [pmc_pkg::WAKE_PINS-1:0] wakeup_interface_pins,
    input wire logic rtc_alarm,
    input wire logic digital_core_regulator_en,
    input wire logic digital_core_regulator_low,
    input wire logic cpu_halt,
    input wire logic sys_reset,
    input wire logic osc_en,
    input wire logic [pmc_pkg::SENSOR_W-1:0] sensor_en,
    input wire logic analog_reg_en,
    input wire logic supervisor_en,
    input wire logic rtc_en,
    input wire logic rtc_alarm_en,
    input wire logic wakeup_ctrl_en
);
    wire logic core = digital_core_regulator_en;
    wire logic [3:0] wp = wakeup_interface_pins;
    wire logic low = cpu_halt || !core;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence ctrl_wr_s;
        psel && penable && pwrite && paddr == 8'h00 && !cpu_halt && !sys_reset && core;
    endsequence
    sequence boot_hold_s;
        sys_reset [*8] ##1 sys_reset [*8] ##1 sys_reset [*4] ##1 !sys_reset;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    chk_enter_standby: assert property (
        ctrl_wr_s ##0 pwdata[5:4] == 2'h1 |=> cpu_halt && core) else $error("no standby");
    chk_enter_sleep: assert property (
        ctrl_wr_s ##0 pwdata[5:4] == 2'h2 |=> !core && sys_reset) else $error("no sleep");
    chk_run_powered: assert property (
        !cpu_halt && !sys_reset |-> core && !digital_core_regulator_low && osc_en
        && supervisor_en) else $error("run not powered");
    chk_standby_off: assert property (
        cpu_halt |-> digital_core_regulator_low && core && !osc_en && sensor_en == 8'h00
        && !analog_reg_en && !supervisor_en) else $error("standby domains on");
    chk_sleep_off: assert property (
        !core |-> sys_reset && !osc_en && !analog_reg_en && sensor_en == 8'h00
        && !supervisor_en && !cpu_halt) else $error("sleep domains on");
    chk_run_stays: assert property (
        core && !cpu_halt && !sys_reset && !(psel && penable)
        |=> core && !cpu_halt && !sys_reset) else $error("run left");
    chk_wake_fall: assert property (
        low && wakeup_ctrl_en && ($fell(wp[0]) || $fell(wp[1]))
        |=> core && !cpu_halt) else $error("falling pin no wake");
    chk_wake_rise: assert property (
        low && wakeup_ctrl_en && ($rose(wp[2]) || $rose(wp[3]))
        |=> core && !cpu_halt) else $error("rising pin no wake");
    chk_alarm_wake: assert property (
        low && rtc_en && rtc_alarm_en && rtc_alarm |=> core && !cpu_halt)
        else $error("alarm no wake");
    chk_boot_hold: assert property (
        $rose(core) && sys_reset |-> boot_hold_s) else $error("boot hold wrong");
    chk_apb_answer: assert property (
        psel && !penable |=> pready && pslverr == ($past(paddr) > 8'h18
        || ($past(paddr) & 8'h03) != 8'h00)) else $error("apb answer wrong");
endmodule // power_mode_controller_sva
`default_nettype wire

// *** bench/power_mode_controller_test.sv ***
/*
 * Self-checking bench for the mode controller: APB master, wake model.
 * Assumes the package, design and checker files are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module power_mode_controller_test;
    import pmc_pkg::*;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, cpu_halt, sys_reset, irq;
    logic digital_core_regulator_en, digital_core_regulator_low, clk_sel_ext, osc_en;
    logic analog_reg_en, supervisor_en, rtc_en, rtc_alarm_en, wakeup_ctrl_en;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, sv, rv;
    logic [SENSOR_W-1:0] sensor_en;
    wire logic [WAKE_PINS-1:0] wakeup_interface_pins;
    wire logic rtc_alarm;
    logic [32:0] q[$];
    int n_mismatch = 0;
    int n_checks = 0;
    int n;
    power_mode_controller DUT (.*);
    wake_source ws (.clk(clk), .pins(wakeup_interface_pins), .alarm(rtc_alarm));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // expectation {pslverr, read data} is queued; writes expect data 0
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int k;
        q.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        @(posedge clk);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        apb(1'b0, a, 32'h0, {1'b0, v});
    endtask
    always @(posedge clk) begin
        if (psel && penable && pready)
            chk({pslverr, pwrite ? 32'h0 : prdata}, q.pop_front());
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(68));
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(OFS_CTRL, 32'h0);
        rd(OFS_SENSOR, 32'h0);
        rd(OFS_LPCFG, 32'h7);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_RETAIN, 32'h0);
        apb(1'b0, 8'h1c, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 8'h06, 32'h0, {1'b1, 32'h0});
        sv = {24'h0, 8'($urandom)};
        rv = $urandom;
        wr(OFS_CTRL, 32'h1);
        wr(OFS_SENSOR, sv);
        wr(OFS_RETAIN, rv);
        wr(OFS_IRQ_MASK, 32'h3f);
        chk({clk_sel_ext, sensor_en, analog_reg_en}, {1'b1, sv[7:0], sv[0]});
        for (int i = 0; i < 4; i++)
            ws.pulse(i);
        ws.ring();
        rd(OFS_STATUS, 32'h0);
        rd(OFS_IRQ_STAT, 32'h0);
        // each wake source in turn; index 4 is the alarm
        for (int i = 0; i < 5; i++) begin
            wr(OFS_CTRL, 32'h11);
            chk({cpu_halt, digital_core_regulator_low, osc_en, supervisor_en, sensor_en},
                {4'b1100, 8'h0});
            if (i < 4)
                ws.pulse(i);
            else
                ws.ring();
            rd(OFS_STATUS, 32'h0);
            chk(irq, 1'b1);
            rd(OFS_IRQ_STAT, 32'h1 << ((i + 1) % 5));
            wr(OFS_IRQ_STAT, 32'h3f);
            @(posedge clk);
            chk({irq, sensor_en, clk_sel_ext}, {1'b0, sv[7:0], 1'b1});
        end
        wr(OFS_LPCFG, 32'h0);
        wr(OFS_CTRL, 32'h10);
        chk({rtc_en, rtc_alarm_en, wakeup_ctrl_en}, 3'h0);
        ws.pulse(0);
        ws.ring();
        rd(OFS_STATUS, 32'h1);
        wr(OFS_LPCFG, 32'h4);
        ws.pulse(3);
        rd(OFS_STATUS, 32'h0);
        wr(OFS_CTRL, 32'h30);
        rd(OFS_STATUS, 32'h0);
        wr(OFS_CTRL, 32'h20);
        chk({digital_core_regulator_en, sys_reset, osc_en, analog_reg_en, supervisor_en,
             sensor_en}, {5'b01000, 8'h0});
        ws.pulse(1);
        rd(OFS_STATUS, 32'h3);
        n = 0;
        while (sys_reset !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        rd(OFS_STATUS, 32'h0);
        rd(OFS_RETAIN, rv);
        rd(OFS_SENSOR, 32'h0);
        // pin 3 wake from the standby pass is still pending, plus pin 1 and sleep exit
        rd(OFS_IRQ_STAT, 32'h34);
        chk({irq, q.size()}, 33'h0);
        test_done();
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
endmodule // power_mode_controller_test
bind power_mode_controller power_mode_controller_sva chk (.*);
`default_nettype wire

// *** bench/wake_source.sv ***
/*
 * Far-side model: four wake pins and the clock alarm.
 * Assumes the bench calls its tasks just after a rising clk edge.
 */
`timescale 1ns/1ns
`default_nettype none
module wake_source (
    input wire logic clk,
    output logic [3:0] pins,
    output logic alarm
);
    initial begin
        pins = 4'h3; // falling-edge pins idle high
        alarm = 1'b0;
    end
    // active edge, then back after two cycles so the next pulse is clean
    task automatic pulse(input int i);
        @(posedge clk);
        pins[i] <= ~pins[i];
        repeat (2) @(posedge clk);
        pins[i] <= ~pins[i];
        @(posedge clk);
    endtask
    task automatic ring();
        @(posedge clk);
        alarm <= 1'b1;
        @(posedge clk);
        alarm <= 1'b0;
        @(posedge clk);
    endtask
endmodule // wake_source
`default_nettype wire

// *** rtl/apb_word_decode.sv ***
/*
 * APB address decoder: word-aligned byte offset and hit flag for the register map.
 * Assumes byte addresses with one aligned 32-bit word per register.
 */
`timescale 1ns/1ns
`default_nettype none
module apb_word_decode (
    input wire logic [pmc_pkg::ADDR_W-1:0] paddr,
    output logic [pmc_pkg::ADDR_W-1:0] offset,
    output logic hit
);
    import pmc_pkg::*;

    // unaligned or out-of-map addresses answer with an error
    always_comb begin
        offset = {paddr[ADDR_W-1:2], 2'h0};
        hit = (paddr[1:0] == 2'h0) && (paddr <= OFS_LAST);
    end

endmodule // apb_word_decode
`default_nettype wire

// *** rtl/pmc_pkg.sv ***
/*
 * Shared constants for the operating-mode controller: register map,
 * field positions, reset values, mode encoding and timing counts.
 * Assumes a 32-bit APB register bus and a single 100 MHz clock.
 */
package pmc_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int WAKE_PINS = 4;
    localparam int SENSOR_W = 8;
    localparam int LP_W = 3;
    localparam int IRQ_W = 6;
    localparam int BOOT_CNT_W = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SENSOR = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_LPCFG = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_RETAIN = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_LAST = OFS_RETAIN;

    // control register fields
    localparam int CTRL_CLK_EXT_BIT = 0;
    localparam int CTRL_REQ_LSB = 4;
    localparam logic [1:0] REQ_STANDBY = 2'h1;
    localparam logic [1:0] REQ_SLEEP = 2'h2;

    // low-power configuration fields
    localparam int LP_RTC_EN_BIT = 0;
    localparam int LP_ALARM_EN_BIT = 1;
    localparam int LP_WAKE_EN_BIT = 2;

    // sensor enable field that gates the analog supply regulator
    localparam int SENSOR_AREG_BIT = 0;

    // interrupt status fields
    localparam int IRQ_ALARM_BIT = 0;
    localparam int IRQ_PIN_LSB = 1;
    localparam int IRQ_SLEEP_EXIT_BIT = 5;

    // wake pins whose falling edge counts; the rest use the rising edge
    localparam logic [WAKE_PINS-1:0] WAKE_FALL_MASK = 4'h3;

    // reset values
    localparam logic CTRL_CLK_EXT_RST = 1'b0;
    localparam logic [SENSOR_W-1:0] SENSOR_RST = 8'h00;
    localparam logic [LP_W-1:0] LPCFG_RST = 3'h7;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 6'h00;
    localparam logic [DATA_W-1:0] RETAIN_RST = 32'h00000000;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BOOT_HOLD_NS = 200;
    localparam int BOOT_HOLD_CYCLES = (BOOT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_STANDBY,
        MODE_SLEEP,
        MODE_BOOT
    } mode_e;

endpackage

// *** rtl/power_mode_controller.sv ***
/*
 * Operating-mode controller: run, standby and sleep sequencing, wake
 * handling, power-domain enables, retention word and APB register file.
 * Assumes synchronous wake pins and alarm, and an APB master on clk.
 */
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - In run mode the digital core regulator is switched on at full voltage.
// - In run mode the processor clock source is internal or external per a control bit.
// - In run mode each sensor-interface component has its own software enable bit.
// - From run mode a software request enters standby or sleep, and only that mode.
// - In standby the processor is halted and the core regulator lowered, keeping all state.
// - Entering standby switches off every sensor-interface component and analog supply.
// - Entering standby switches off the internal oscillator without software help.
// - In standby and sleep the clock, alarm and wake controller follow their own enables.
// - An enabled alarm or any enabled wake pin event returns standby or sleep to run.
// - Entering sleep powers down core and analog regulators, oscillator and sensors.
// - Leaving sleep resets the system and restarts the processor from the boot program.
// - A retention word keeps its contents through sleep and the reset after it.
// - The first two wake pins wake the device on a falling edge.
// - The other two wake pins wake the device on a rising edge.
// - Supply monitoring is off in standby and sleep and on again in run.
module power_mode_controller (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pmc_pkg::ADDR_W-1:0] paddr,
    input wire logic [pmc_pkg::DATA_W-1:0] pwdata,
    output logic [pmc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [pmc_pkg::WAKE_PINS-1:0] wakeup_interface_pins,
    input wire logic rtc_alarm,
    output logic digital_core_regulator_en,
    output logic digital_core_regulator_low,
    output logic cpu_halt,
    output logic sys_reset,
    output logic clk_sel_ext,
    output logic osc_en,
    output logic [pmc_pkg::SENSOR_W-1:0] sensor_en,
    output logic analog_reg_en,
    output logic supervisor_en,
    output logic rtc_en,
    output logic rtc_alarm_en,
    output logic wakeup_ctrl_en,
    output logic irq
);
    import pmc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        mode_e mode;
        logic [BOOT_CNT_W-1:0] cnt;
        logic clk_ext;
        logic [SENSOR_W-1:0] sensor;
        logic [LP_W-1:0] lpcfg;
        logic [IRQ_W-1:0] stat;
        logic [IRQ_W-1:0] mask;
        logic [DATA_W-1:0] retain;
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic core_en;
        logic core_low;
        logic halt;
        logic sys_rst;
        logic osc;
        logic [SENSOR_W-1:0] sensor_out;
        logic areg;
        logic sup;
    } ctl_s;

    localparam ctl_s CTL_RST = '{
        mode: MODE_RUN,
        cnt: '0,
        clk_ext: CTRL_CLK_EXT_RST,
        sensor: SENSOR_RST,
        lpcfg: LPCFG_RST,
        stat: '0,
        mask: IRQ_MASK_RST,
        retain: RETAIN_RST,
        prdata: '0,
        pready: 1'b0,
        pslverr: 1'b0,
        irq: 1'b0,
        core_en: 1'b1,
        core_low: 1'b0,
        halt: 1'b0,
        sys_rst: 1'b0,
        osc: 1'b1,
        sensor_out: SENSOR_RST,
        areg: SENSOR_RST[SENSOR_AREG_BIT],
        sup: 1'b1
    };

    localparam logic [BOOT_CNT_W-1:0] BOOT_LOAD = BOOT_CNT_W'(BOOT_HOLD_CYCLES - 1);

    ctl_s s_q;
    ctl_s s_d;

    logic [ADDR_W-1:0] offset;
    logic hit;
    logic [WAKE_PINS-1:0] pin_evt;

    ////////////////////////////////////////////////////////////////////////////

    apb_word_decode u_decode (
        .paddr(paddr),
        .offset(offset),
        .hit(hit)
    );

    wake_edge_detect #(
        .PINS(WAKE_PINS),
        .FALL_MASK(WAKE_FALL_MASK)
    ) u_wake (
        .clk(clk),
        .nrst(nrst),
        .pins(wakeup_interface_pins),
        .events(pin_evt)
    );

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] ofs,
                                                   input ctl_s s);
        logic [DATA_W-1:0] w;
        w = '0;
        unique case (ofs)
            OFS_CTRL: w[CTRL_CLK_EXT_BIT] = s.clk_ext;
            OFS_SENSOR: w[SENSOR_W-1:0] = s.sensor;
            OFS_LPCFG: w[LP_W-1:0] = s.lpcfg;
            OFS_STATUS: w[1:0] = s.mode;
            OFS_IRQ_STAT: w[IRQ_W-1:0] = s.stat;
            OFS_IRQ_MASK: w[IRQ_W-1:0] = s.mask;
            OFS_RETAIN: w = s.retain;
            default: w = '0;
        endcase
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    logic wr_en;
    logic [1:0] req;
    logic [WAKE_PINS-1:0] pin_wake;
    logic alarm_wake;
    logic wake_any;
    logic [IRQ_W-1:0] wake_cause;

    always_comb begin
        s_d = s_q;
        wr_en = 1'b0;
        req = 2'h0;
        pin_wake = '0;
        alarm_wake = 1'b0;
        wake_any = 1'b0;
        wake_cause = '0;

        // bus slave: data and error are captured in setup, so access is one cycle
        s_d.pready = psel & ~penable;
        s_d.pslverr = psel & ~penable & ~hit;
        if (psel && !penable) begin
            s_d.prdata = hit ? read_word(offset, s_q) : '0;
        end
        wr_en = psel & penable & s_q.pready & pwrite & ~s_q.pslverr;

        if (wr_en) begin
            unique case (offset)
                OFS_CTRL: begin
                    s_d.clk_ext = pwdata[CTRL_CLK_EXT_BIT];
                    req = pwdata[CTRL_REQ_LSB +: 2];
                end
                OFS_SENSOR: s_d.sensor = pwdata[SENSOR_W-1:0];
                OFS_LPCFG: s_d.lpcfg = pwdata[LP_W-1:0];
                OFS_IRQ_MASK: s_d.mask = pwdata[IRQ_W-1:0];
                OFS_IRQ_STAT: s_d.stat = s_q.stat & ~pwdata[IRQ_W-1:0];
                OFS_RETAIN: s_d.retain = pwdata;
                default: ;
            endcase
        end

        // wake sources: the pins share one wake enable, the alarm needs both the clock and alarm enables
        pin_wake = s_q.lpcfg[LP_WAKE_EN_BIT] ? pin_evt : '0;
        alarm_wake = rtc_alarm & s_q.lpcfg[LP_RTC_EN_BIT] & s_q.lpcfg[LP_ALARM_EN_BIT];
        wake_any = alarm_wake | (|pin_wake);
        wake_cause[IRQ_ALARM_BIT] = alarm_wake;
        wake_cause[IRQ_PIN_LSB +: WAKE_PINS] = pin_wake;

        unique case (s_q.mode)
            MODE_RUN: begin
                // wake events are ignored here
                if (req == REQ_STANDBY) begin
                    s_d.mode = MODE_STANDBY;
                end else if (req == REQ_SLEEP) begin
                    s_d.mode = MODE_SLEEP;
                end
            end
            MODE_STANDBY: begin
                if (wake_any) begin
                    s_d.mode = MODE_RUN;
                    s_d.stat = s_d.stat | wake_cause;
                end
            end
            MODE_SLEEP: begin
                if (wake_any) begin
                    s_d.mode = MODE_BOOT;
                    s_d.cnt = BOOT_LOAD;
                    // clock select, sensor enables and interrupt mask restart from reset values; low-power config and retention word stay
                    s_d.clk_ext = CTRL_CLK_EXT_RST;
                    s_d.sensor = SENSOR_RST;
                    s_d.mask = IRQ_MASK_RST;
                    s_d.stat = s_d.stat | wake_cause;
                    s_d.stat[IRQ_SLEEP_EXIT_BIT] = 1'b1;
                end
            end
            MODE_BOOT: begin
                if (s_q.cnt == '0) begin
                    s_d.mode = MODE_RUN;
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
        endcase

        // power-domain outputs are registered from the next mode
        s_d.core_en = (s_d.mode != MODE_SLEEP);
        s_d.core_low = (s_d.mode == MODE_STANDBY);
        s_d.halt = (s_d.mode == MODE_STANDBY);
        // the processor is held in reset through sleep and the boot hold
        s_d.sys_rst = (s_d.mode == MODE_SLEEP) || (s_d.mode == MODE_BOOT);
        s_d.osc = (s_d.mode == MODE_RUN) || (s_d.mode == MODE_BOOT);
        s_d.sensor_out = (s_d.mode == MODE_RUN) ? s_d.sensor : '0;
        s_d.areg = (s_d.mode == MODE_RUN) && s_d.sensor[SENSOR_AREG_BIT];
        s_d.sup = (s_d.mode == MODE_RUN) || (s_d.mode == MODE_BOOT);
        s_d.irq = |(s_d.stat & s_d.mask);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= CTL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign digital_core_regulator_en = s_q.core_en;
    assign digital_core_regulator_low = s_q.core_low;
    assign cpu_halt = s_q.halt;
    assign sys_reset = s_q.sys_rst;
    assign clk_sel_ext = s_q.clk_ext;
    assign osc_en = s_q.osc;
    assign sensor_en = s_q.sensor_out;
    assign analog_reg_en = s_q.areg;
    assign supervisor_en = s_q.sup;
    assign rtc_en = s_q.lpcfg[LP_RTC_EN_BIT];
    assign rtc_alarm_en = s_q.lpcfg[LP_ALARM_EN_BIT];
    assign wakeup_ctrl_en = s_q.lpcfg[LP_WAKE_EN_BIT];
    assign irq = s_q.irq;

endmodule // power_mode_controller
`default_nettype wire

// *** rtl/wake_edge_detect.sv ***
/*
 * Wake pin edge detector: one-cycle event per pin on the selected edge.
 * Assumes the pins are already synchronous to clk.
 */
`timescale 1ns/1ns
`default_nettype none
module wake_edge_detect #(
    parameter int PINS = 4,
    parameter logic [PINS-1:0] FALL_MASK = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [PINS-1:0] pins,
    output logic [PINS-1:0] events
);

    typedef struct packed {
        logic [PINS-1:0] prev;
        logic primed;
    } det_s;

    det_s s_q;
    det_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.prev = pins;
        s_d.primed = 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // the first sample after reset only primes, so a pin idling high is no edge
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (FALL_MASK[i]) begin
                events[i] = s_q.primed & s_q.prev[i] & ~pins[i];
            end else begin
                events[i] = s_q.primed & ~s_q.prev[i] & pins[i];
            end
        end
    end

endmodule // wake_edge_detect
`default_nettype wire
